// ### rtl/front_end_pkg.sv
// Constants shared by the error front end control logic.
// Assumes a single 20 MHz core clock and an active-low asynchronous reset.
package front_end_pkg;
  localparam int RESULT_W   = 9;
  localparam int RAW_W      = 6;
  localparam int GAIN_W     = 2;
  localparam int DAC_W      = 10;
  localparam int DITHER_W   = 4;
  localparam int SETPT_W    = 14;
  localparam int AVG_SEL_W  = 2;
  localparam int SRC_W      = 2;
  localparam int EVT_W      = 6;
  localparam int SLEW_W     = 14;

  localparam logic signed [RESULT_W-1:0] RESULT_MAX = 9'sh0FF;
  localparam logic signed [RESULT_W-1:0] RESULT_MIN = -9'sh100;

  // Event flag positions.
  localparam int EVT_PREBIAS   = 0;
  localparam int EVT_RAMP_DLY  = 1;
  localparam int EVT_RAMP_DONE = 2;
  localparam int EVT_LOAD_STEP = 3;
  localparam int EVT_OVER_V    = 4;
  localparam int EVT_SAT       = 5;

  // Set-point sources.
  localparam logic [SRC_W-1:0] SRC_FIXED = 2'h0;
  localparam logic [SRC_W-1:0] SRC_RAMP  = 2'h1;
  localparam logic [SRC_W-1:0] SRC_OUTER = 2'h2;

  localparam logic [SETPT_W-1:0]  SETPT_RESET  = 14'h0000;
  localparam logic [GAIN_W-1:0]   GAIN_RESET   = 2'h0;
  localparam logic [EVT_W-1:0]    EVT_RESET    = 6'h00;
  localparam logic [DITHER_W-1:0] DITHER_RESET = 4'h0;

  // Auto gain thresholds on the raw magnitude, with headroom.
  localparam logic [RAW_W-1:0] AUTO_UP_LIMIT = 6'h1F;
  localparam logic [RAW_W-1:0] AUTO_DN_LIMIT = 6'h0F;

  typedef enum logic [2:0] {
    CONV_IDLE = 3'b001,
    CONV_BUSY = 3'b010,
    CONV_DONE = 3'b100
  } conv_state_t;
endpackage

// ### rtl/error_adc_front_end_control.sv
// Digital control of one error-measurement front end: conversion sequencing,
// gain, averaging, set-point DAC with dither and slope ramp, event flags.
// Assumes the converter and modulator run on core_clk; sample requests and
// the converter done strobe are logic on the same clock.
// Assumes the event inputs are single-cycle pulses from logic on core_clk,
// so they are not resynchronised here.
// Assumes software reads the result only between filter strobes.
`timescale 1ns/10ps
module error_adc_front_end_control
  import front_end_pkg::*;
#(
  parameter bit FRONT_END_ZERO = 1'b1
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic                       sample_req,
  output logic                            conv_start,
  input  wire logic                       conv_done,
  input  wire logic signed [RAW_W-1:0]    conv_code,
  input  wire logic                       auto_gain_en,
  input  wire logic [GAIN_W-1:0]          gain_manual,
  output logic [GAIN_W-1:0]               analog_gain_setting,
  input  wire logic [AVG_SEL_W-1:0]       avg_sel,
  input  wire logic                       invert_en,
  input  wire logic                       abs_mode_en,
  output logic signed [RESULT_W-1:0]      error_result,
  output logic                            filter_strobe,
  input  wire logic [SRC_W-1:0]           setpt_src,
  input  wire logic [SETPT_W-1:0]         setpt_fixed,
  input  wire logic [SETPT_W-1:0]         setpt_outer,
  input  wire logic                       peak_mode_en,
  input  wire logic                       cycle_start,
  input  wire logic [SLEW_W-1:0]          slew_step,
  output logic [DAC_W-1:0]                setpt_dac,
  input  wire logic [EVT_W-1:0]           ext_events,
  input  wire logic [EVT_W-1:0]           evt_clear,
  output logic [EVT_W-1:0]                evt_flags,
  output logic                            front_end_irq
);

  conv_state_t                  state_q;
  logic [GAIN_W-1:0]            gain_q;
  logic [GAIN_W-1:0]            conv_gain_q;
  logic signed [RESULT_W+2:0]   acc_q;
  logic [3:0]                   avg_cnt_q;
  logic signed [RESULT_W-1:0]   result_q;
  logic                         strobe_q;
  logic [SETPT_W-1:0]           ramp_q;
  logic [SETPT_W-1:0]           setpt_q;
  logic [DITHER_W-1:0]          dither_q;
  logic [DAC_W-1:0]             dac_q;
  logic [EVT_W-1:0]             flags_q;

  // Scale the raw code by the step size of its gain setting.
  // The shift cannot overflow: the largest raw code times eight still fits.
  function automatic logic signed [RESULT_W-1:0] scale_code(
    input logic signed [RAW_W-1:0] code,
    input logic [GAIN_W-1:0]       g
  );
    logic signed [RESULT_W-1:0] ext;
    ext = RESULT_W'(code);
    scale_code = ext <<< g;
  endfunction

  function automatic logic signed [RESULT_W-1:0] sat9(
    input logic signed [RESULT_W+3:0] v
  );
    if (v > (RESULT_W+4)'(RESULT_MAX)) begin
      sat9 = RESULT_MAX;
    end else if (v < (RESULT_W+4)'(RESULT_MIN)) begin
      sat9 = RESULT_MIN;
    end else begin
      sat9 = v[RESULT_W-1:0];
    end
  endfunction

  logic [3:0] avg_len;
  assign avg_len = 4'h1 << avg_sel;

  logic signed [RESULT_W-1:0] sample_scaled;
  assign sample_scaled = scale_code(conv_code, conv_gain_q);

  logic signed [RESULT_W+2:0] acc_next;
  assign acc_next = acc_q + (RESULT_W+3)'(sample_scaled);

  logic avg_last;
  assign avg_last = (avg_cnt_q + 4'h1) >= avg_len;

  // Average, invert, optional absolute offset, then clamp.
  logic signed [RESULT_W+3:0] avg_val;
  logic signed [RESULT_W+3:0] post_val;
  always_comb begin
    avg_val = (RESULT_W+4)'(acc_next >>> avg_sel);
    if (invert_en) begin
      post_val = -avg_val;
    end else begin
      post_val = avg_val;
    end
    if (abs_mode_en) begin
      post_val = post_val + (RESULT_W+4)'(setpt_q[SETPT_W-1:DITHER_W]);
    end
  end

  // Conversion sequencing. The done state adds one idle cycle, which is the
  // minimum spacing promised to the modulator between requests.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= CONV_IDLE;
    end else begin
      case (state_q)
        CONV_IDLE: begin
          if (sample_req) begin
            state_q <= CONV_BUSY;
          end
        end
        CONV_BUSY: begin
          if (conv_done) begin
            state_q <= CONV_DONE;
          end
        end
        CONV_DONE: begin
          state_q <= CONV_IDLE;
        end
        default: begin
          state_q <= CONV_IDLE;
        end
      endcase
    end
  end

  // Start is combinational so the converter sees the request in its own
  // cycle; requests that arrive while busy are dropped, not queued.
  assign conv_start = (state_q == CONV_IDLE) && sample_req;

  // Gain is frozen for each conversion so the code scales consistently.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_gain_q <= GAIN_RESET;
    end else if (conv_start) begin
      conv_gain_q <= gain_q;
    end
  end

  // Auto gain: coarsen when the raw code nears full scale, refine when small.
  // The gap between the two thresholds keeps the gain from hunting when the
  // signal sits right at one step boundary.
  logic [RAW_W-1:0] raw_mag;
  always_comb begin
    if (conv_code[RAW_W-1]) begin
      raw_mag = RAW_W'(-conv_code);
    end else begin
      raw_mag = conv_code;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_q <= GAIN_RESET;
    end else if (!(FRONT_END_ZERO && auto_gain_en)) begin
      gain_q <= gain_manual;
    end else if (state_q == CONV_BUSY && conv_done) begin
      if (raw_mag >= AUTO_UP_LIMIT && gain_q != 2'h3) begin
        gain_q <= gain_q + 2'h1;
      end else if (raw_mag < AUTO_DN_LIMIT && gain_q != 2'h0) begin
        gain_q <= gain_q - 2'h1;
      end
    end
  end
  assign analog_gain_setting = gain_q;

  logic conv_end;
  assign conv_end = (state_q == CONV_BUSY) && conv_done;

  // Averaging accumulator, cleared once a full group has been averaged.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q     <= '0;
      avg_cnt_q <= 4'h0;
    end else if (conv_end) begin
      if (avg_last) begin
        acc_q     <= '0;
        avg_cnt_q <= 4'h0;
      end else begin
        acc_q     <= acc_next;
        avg_cnt_q <= avg_cnt_q + 4'h1;
      end
    end
  end

  // The result holds between strobes so the filter may read it at leisure.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= '0;
    end else if (conv_end && avg_last) begin
      result_q <= sat9(post_val);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= conv_end && avg_last;
    end
  end
  assign error_result  = result_q;
  assign filter_strobe = strobe_q;

  // Slope ramp: reload at each switching cycle, then step down by the slew.
  // The ramp floors at zero instead of wrapping, which would otherwise throw
  // the set point to full scale late in a long switching period.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_q <= SETPT_RESET;
    end else if (cycle_start || !peak_mode_en) begin
      ramp_q <= setpt_fixed;
    end else if (ramp_q > slew_step) begin
      ramp_q <= ramp_q - slew_step;
    end else begin
      ramp_q <= SETPT_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      setpt_q <= SETPT_RESET;
    end else begin
      // Unused source codes fall back to the fixed value, or to the ramp
      // in peak mode, so no code can leave the set point stale.
      case (setpt_src)
        SRC_RAMP: begin
          setpt_q <= ramp_q;
        end
        SRC_OUTER: begin
          setpt_q <= setpt_outer;
        end
        default: begin
          setpt_q <= peak_mode_en ? ramp_q : setpt_fixed;
        end
      endcase
    end
  end

  // First-order dither: the fraction accumulates and carries into the DAC,
  // so the 10-bit DAC averages to the full 14-bit set point, except when its top ten bits are all ones.
  logic [DITHER_W:0] dither_sum;
  assign dither_sum = {1'b0, dither_q} + {1'b0, setpt_q[DITHER_W-1:0]};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dither_q <= DITHER_RESET;
    end else begin
      dither_q <= dither_sum[DITHER_W-1:0];
    end
  end

  // The carry is dropped at full scale so the DAC code never wraps to zero.
  logic dac_carry;
  assign dac_carry = dither_sum[DITHER_W] &&
                     (setpt_q[SETPT_W-1:DITHER_W] != '1);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_q <= '0;
    end else if (dac_carry) begin
      dac_q <= setpt_q[SETPT_W-1:DITHER_W] + 10'h001;
    end else begin
      dac_q <= setpt_q[SETPT_W-1:DITHER_W];
    end
  end
  assign setpt_dac = dac_q;

  // Sticky event flags; a new event wins over a clear in the same cycle.
  logic [EVT_W-1:0] evt_set;
  always_comb begin
    evt_set = ext_events;
    evt_set[EVT_SAT] = ext_events[EVT_SAT] ||
      (strobe_q &&
       (result_q == RESULT_MAX || result_q == RESULT_MIN));
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= EVT_RESET;
    end else begin
      flags_q <= (flags_q & ~evt_clear) | evt_set;
    end
  end
  assign evt_flags     = flags_q;
  assign front_end_irq = |flags_q;

endmodule

// ### verification/fe_props.sv
// Port checker for the error front end control block.
// Assumes it is bound to error_adc_front_end_control.
`timescale 1ns/10ps
module fe_props
  import front_end_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              sample_req,
  input wire logic              conv_start,
  input wire logic              conv_done,
  input wire logic              filter_strobe,
  input wire logic signed [8:0] error_result,
  input wire logic [5:0]        ext_events,
  input wire logic [5:0]        evt_clear,
  input wire logic [5:0]        evt_flags,
  input wire logic              front_end_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_start_on_req: assert property (conv_start |-> sample_req)
    else $error("start without request");
  chk_start_spacing: assert property (conv_start |=> !conv_start [*2])
    else $error("start while busy");
  chk_strobe_after_done: assert property (
    filter_strobe |-> $past(conv_done) && !$past(filter_strobe))
    else $error("strobe without done");
  chk_result_holds: assert property (
    !filter_strobe |-> $stable(error_result))
    else $error("result moved without strobe");
  chk_irq_is_or: assert property (front_end_irq == (|evt_flags))
    else $error("irq not OR of flags");
  chk_event_sets: assert property (
    (|ext_events) |=> (evt_flags & $past(ext_events)) == $past(ext_events))
    else $error("event not captured");
  chk_flags_sticky: assert property (
    ($past(evt_flags) & ~$past(evt_clear) & ~evt_flags) == 6'h00)
    else $error("flag dropped without clear");
  chk_sat_flagged: assert property (
    filter_strobe && (error_result == RESULT_MAX || error_result == RESULT_MIN)
    |=> evt_flags[EVT_SAT])
    else $error("saturation not flagged");
endmodule
bind error_adc_front_end_control fe_props chk (.core_clk, .rst_b,
  .sample_req, .conv_start, .conv_done, .filter_strobe, .error_result,
  .ext_events, .evt_clear, .evt_flags, .front_end_irq);

// ### verification/fe_partner_model.sv
// Modulator trigger and error converter model for the front end bench.
// Assumes one clock; the bench steers it through run, os_sel and code_in.
`timescale 1ns/10ps
module fe_partner_model (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              run,
  input  wire logic [1:0]        os_sel,
  input  wire logic              conv_start,
  input  wire logic signed [5:0] code_in,
  output logic                   sample_req,
  output logic                   conv_done,
  output logic signed [5:0]      conv_code
);
  logic [5:0] cnt_q;
  logic [1:0] wait_q;
  logic       slow_q;
  // The code toggles outside its done cycle so a late capture is seen.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {cnt_q, wait_q, slow_q, sample_req, conv_done, conv_code} <= '0;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      sample_req <= run && (cnt_q & (6'h3F >> os_sel)) == 6'h05;
      conv_done <= 1'b0;
      conv_code <= ~conv_code;
      if (conv_start) begin
        wait_q <= slow_q ? 2'h3 : 2'h1;
        slow_q <= ~slow_q;
      end else if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
        conv_done <= wait_q == 2'h1;
        conv_code <= wait_q == 2'h1 ? code_in : ~conv_code;
      end
    end
  end
endmodule

// ### verification/tb_error_adc_front_end_control.sv
// Self-checking bench for the error front end control block.
// Assumes the partner model issues requests and answers conversions.
`timescale 1ns/10ps
module tb_error_adc_front_end_control;
  import front_end_pkg::*;
  logic        core_clk, rst_b, run, sample_req, conv_start, conv_done;
  logic        auto_gain_en, invert_en, abs_mode_en, peak_mode_en;
  logic        cycle_start, filter_strobe, front_end_irq, iv, sat;
  logic [1:0]  gain_manual, analog_gain_setting, os_sel, avg_sel, setpt_src;
  logic [5:0]  ext_events, evt_clear, evt_flags;
  logic [9:0]  setpt_dac;
  logic [13:0] setpt_fixed, setpt_outer, slew_step;
  logic [15:0] e;
  logic signed [5:0] code_in, conv_code;
  logic signed [8:0] error_result;
  int          fail_count, total_checks, cyc, n;
  error_adc_front_end_control uut (.core_clk, .rst_b, .sample_req,
    .conv_start, .conv_done, .conv_code, .auto_gain_en, .gain_manual,
    .analog_gain_setting, .avg_sel, .invert_en, .abs_mode_en,
    .error_result, .filter_strobe, .setpt_src, .setpt_fixed, .setpt_outer,
    .peak_mode_en, .cycle_start, .slew_step, .setpt_dac, .ext_events,
    .evt_clear, .evt_flags, .front_end_irq);
  fe_partner_model far_end (.core_clk, .rst_b, .run, .os_sel, .conv_start,
    .code_in, .sample_req, .conv_done, .conv_code);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] exp_res(logic signed [5:0] c,
      logic [1:0] g, logic v_inv, ab);
    int v;
    v = int'(c) * (1 << g);
    if (v_inv) v = -v;
    if (ab) v = v + int'(setpt_fixed[13:4]);
    if (v > 255) v = 255;
    if (v < -256) v = -256;
    return 16'(v);
  endfunction
  // Flags are cleared first so the saturation check sees only this result.
  task automatic conv(logic signed [5:0] c, logic [1:0] g, a, logic v_inv, ab);
    e = exp_res(c, g, v_inv, ab);
    sat = e == 16'h00FF || e == 16'hFF00;
    @(negedge core_clk);
    evt_clear = 6'h3F;
    {code_in, gain_manual, avg_sel, invert_en, abs_mode_en} =
      {c, g, a, v_inv, ab};
    @(negedge core_clk);
    evt_clear = 6'h00;
    run = 1'b1;
    n = 0;
    for (int k = 0; k < 900 && filter_strobe !== 1'b1; k++) begin
      @(negedge core_clk);
      n += int'(conv_done === 1'b1);
    end
    run = 1'b0;
    check("samples", 16'(1 << a), 16'(n));
    if (!auto_gain_en) begin
      check("result", e, error_result);
      check("gain", 16'(g), analog_gain_setting);
    end
    @(negedge core_clk);
    check("sat", 16'(sat), evt_flags[EVT_SAT]);
  endtask
  initial begin
    {run, auto_gain_en, invert_en, abs_mode_en, peak_mode_en} = '0;
    {cycle_start, gain_manual, os_sel, avg_sel, setpt_src, code_in} = '0;
    {ext_events, evt_clear, slew_step, setpt_outer} = '0;
    setpt_fixed = 14'h0140;
    rst_b = 1'b0;
    n = $urandom(32'hC1342099);
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ext_events = 6'h01 << i;
      @(negedge core_clk);
      ext_events = 6'h00;
      repeat (3) @(negedge core_clk);
      check("flag", 16'h1 << i, evt_flags);
      check("irq", 16'h1, front_end_irq);
      evt_clear = 6'h3F;
      @(negedge core_clk);
      evt_clear = 6'h00;
      check("cleared", 16'h0, evt_flags);
    end
    conv(-6'sd32, 2'h3, 2'h0, 1'b0, 1'b0);
    conv(-6'sd32, 2'h3, 2'h1, 1'b1, 1'b0);
    conv(6'sd31, 2'h3, 2'h3, 1'b0, 1'b1);
    repeat (16) begin
      os_sel = 2'($urandom);
      iv = 1'($urandom);
      conv(6'($urandom), 2'($urandom), 2'($urandom), iv, !iv && 1'($urandom));
    end
    auto_gain_en = 1'b1;
    repeat (6) conv(6'sd31, 2'h0, 2'h0, 1'b0, 1'b0);
    check("gain up", 16'h3, analog_gain_setting);
    repeat (6) conv(6'sd1, 2'h0, 2'h0, 1'b0, 1'b0);
    check("gain down", 16'h0, analog_gain_setting);
    {setpt_src, setpt_outer} = {SRC_OUTER, 14'h0450};
    repeat (4) @(negedge core_clk);
    check("outer", 16'h045, setpt_dac);
    {setpt_src, setpt_fixed} = {SRC_FIXED, 14'h1238};
    repeat (2) @(negedge core_clk);
    n = 0;
    repeat (16) begin
      @(negedge core_clk);
      n += int'(setpt_dac === 10'h124);
      e = 16'(setpt_dac);
      check("dac", 16'h1, 16'(e == 16'h124 || e == 16'h123));
    end
    check("dither", 16'h1, 16'(n > 1 && n < 16));
    {setpt_src, peak_mode_en, setpt_fixed} = {SRC_RAMP, 1'b1, 14'h1000};
    {slew_step, cycle_start} = {14'h0010, 1'b1};
    @(negedge core_clk);
    cycle_start = 1'b0;
    repeat (4) @(negedge core_clk);
    check("slope", 16'h1, 16'(setpt_dac > 10'h0F0 && setpt_dac < 10'h100));
    repeat (300) @(negedge core_clk);
    check("floor", 16'h0, setpt_dac);
    end_sim();
  end
endmodule
